//--- include/pfds_pkg.sv
// Package with the register map, field layout and carrier types of the pin function block.
package pfds_pkg;

    // ------------------------------------------------------------------
    // Bus and register widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 10;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------
    localparam int IDX_DRV_LVL_2 = 0;
    localparam int IDX_DRV_LVL_3 = 1;
    localparam int IDX_PA_FUNC_LO = 2;
    localparam int IDX_PA_FUNC_HI = 3;
    localparam int IDX_PB_FUNC_LO = 4;
    localparam int IDX_PC_FUNC_LO = 5;
    localparam int IDX_PC_FUNC_HI = 6;
    localparam int IDX_PD_FUNC_LO = 7;
    localparam int IDX_PD_FUNC_HI = 8;
    localparam int IDX_PE_FUNC_LO = 9;
    localparam int IDX_PE_FUNC_HI = 10;
    localparam int IDX_PF_FUNC_LO = 11;
    localparam int IDX_PF_FUNC_HI = 12;
    localparam int IDX_PG_FUNC_LO = 13;
    localparam int IDX_IN_ROUTE_0 = 14;
    localparam int IDX_IN_ROUTE_1 = 15;
    localparam int IDX_DIR_PA = 16;
    localparam int IDX_DIR_PG = 22;
    localparam int IDX_DRV_ACT_PE = 23;
    localparam int IDX_DRV_ACT_PF = 24;
    localparam int IDX_DRV_ACT_PG = 25;
    localparam int NUM_RW = 23;
    localparam int NUM_REGS = 26;

    // ------------------------------------------------------------------
    // Implemented bits and reset values of the writable registers
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] RW_MASK [NUM_RW] = '{
        8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hC9, 8'h70,
        8'hFF, 8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h07};
    localparam logic [REG_W-1:0] RW_RST [NUM_RW] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hFF, 8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h07};

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DRV_FLD_W = 2;
    localparam int DRV_PE_LO_LSB = 0;
    localparam int DRV_PE_HI_LSB = 2;
    localparam int DRV_PF_LO_LSB = 4;
    localparam int DRV_PF_HI_LSB = 6;
    localparam int DRV_PG_LSB = 0;
    localparam int GRP_PINS = 4;
    localparam int NUM_GRP = 5;
    localparam int DRV_PINS = 19;
    localparam int RT0_CAP2 = 7;
    localparam int RT0_CAP1 = 6;
    localparam int RT0_TMR2_CLK = 3;
    localparam int RT0_STD_CLK = 0;
    localparam int RT1_SER_A_SEL = 6;
    localparam int RT1_SER_A_DIN = 5;
    localparam int RT1_SER_A_CLK = 4;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {LVL_MIN, LVL_1, LVL_2, LVL_MAX} pfds_lvl_t;

    typedef struct packed {
        logic act;
        pfds_lvl_t lvl;
    } pfds_pin_drv_t;

    typedef struct packed {
        pfds_pin_drv_t [2:0] pg;
        pfds_pin_drv_t [7:0] pf;
        pfds_pin_drv_t [7:0] pe;
    } pfds_drive_t;

    typedef struct packed {
        logic [2:0][1:0] pg;
        logic [7:0][1:0] pf;
        logic [7:0][1:0] pe;
        logic [7:0][1:0] pd;
        logic [5:0][1:0] pc;
        logic [3:0][1:0] pb;
        logic [7:0][1:0] pa;
    } pfds_func_t;

    typedef struct packed {
        logic [2:0] pg;
        logic [7:0] pf;
        logic [7:0] pe;
        logic [7:0] pd;
        logic [5:0] pc;
        logic [3:0] pb;
        logic [7:0] pa;
    } pfds_dir_t;

    typedef struct packed {
        logic capture2_input_pin_route;
        logic capture1_input_pin_route;
        logic timer2_clock_pin_route;
        logic std_timer_clock_pin_route;
        logic serial_a_select_pin_route;
        logic serial_a_data_in_pin_route;
        logic serial_a_clock_pin_route;
    } pfds_route_t;

endpackage

//--- hdl/pfds_cfg_reg.sv
// One eight-bit configuration register with a fixed mask of implemented bits.
`timescale 1ns/1ps
module pfds_cfg_reg #(
    parameter logic [7:0] MASK = 8'hFF,
    parameter logic [7:0] RST = 8'h00
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Write port.
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    // Stored value.
    output logic [7:0] q_o
);

    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // Bits outside the mask never store, so they read back as zero.
    assign q_nxt = we_i ? (wdata_i & MASK) : q_r; // R14

    // Reset takes the masked constant only.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_r <= RST & MASK; // R14
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;

endmodule

//--- hdl/pfds_top.sv
// Pin function, direction and source-current level selection with an APB slave.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps

// Function
// R01: Two-bit drive code 00..11 selects source level 0 (min) to 3 (max).
// R02: Level register two bits 7:6 drive port F pins 7..4.
// R03: Level register two bits 5:4 drive port F pins 3..0.
// R04: Level register two bits 3:2 drive port E pins 7..4.
// R05: Level register two bits 1:0 drive port E lower pins down to 0.
// R06: Level register three bits 7:2 are absent and read zero.
// R07: Level register three bits 1:0 drive port G pins 2..0.
// R08: Per-port output function selects plus input route selects choose pin roles.
// R09: Software selects pin function, then sets up, then enables peripheral.
// R10: Software also sets direction to input for inputs sharing the GPIO code.
// R11: Software disables the peripheral before changing the pin function.
// R12: Direction bit 1 makes a pin input, 0 a push-pull output.
// R13: Source level acts only while pins are push-pull outputs.
// R14: Absent bits ignore writes; implemented fields clear on power-on reset (the direction registers here reset to all ones).
module pfds_top (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [pfds_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [pfds_pkg::DATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [pfds_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Pin configuration towards the pad ring.
    output pfds_pkg::pfds_func_t func_sel_o,
    output pfds_pkg::pfds_dir_t dir_in_o,
    output pfds_pkg::pfds_drive_t drive_o,
    output pfds_pkg::pfds_route_t in_route_o
);

    // ------------------------------------------------------------------
    // Bus phase decode
    // ------------------------------------------------------------------

    logic setup_ph;
    logic access_ph;
    logic [pfds_pkg::IDX_W-1:0] reg_idx;
    logic addr_hit;
    logic wr_go;
    logic lane0_on;
    logic pready_r;
    logic [pfds_pkg::DATA_W-1:0] rd_word;

    // The index is the word address; byte offsets inside a word are refused.
    assign setup_ph = psel_i & ~penable_i;
    assign reg_idx = paddr_i[pfds_pkg::ADDR_W-1:2];
    assign addr_hit = (paddr_i[1:0] == 2'h0)
        && (reg_idx < pfds_pkg::IDX_W'(pfds_pkg::NUM_REGS));

    // Writes commit only at the access edge at which ready is seen high.
    assign access_ph = psel_i & penable_i & pready_r;
    assign lane0_on = pstrb_i[0];
    assign wr_go = access_ph & pwrite_i & addr_hit & lane0_on;

    // ------------------------------------------------------------------
    // Bus answer registers
    // ------------------------------------------------------------------

    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [pfds_pkg::DATA_W-1:0] prdata_r;
    logic [pfds_pkg::DATA_W-1:0] prdata_nxt;

    // Ready rises for exactly the first access cycle, so every transfer
    // completes with no wait state and a fresh setup may follow at once.
    assign pready_nxt = setup_ph;
    assign pslverr_nxt = setup_ph ? ~addr_hit : 1'b0;
    assign prdata_nxt = (setup_ph && !pwrite_i) ? rd_word : '0;

    // Answer flops; read data is captured during setup while the address
    // is already stable, which keeps the read path off the access edge.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign prdata_o = prdata_r;

    // ------------------------------------------------------------------
    // Writable register file
    // ------------------------------------------------------------------

    logic [pfds_pkg::REG_W-1:0] cfg_q [pfds_pkg::NUM_RW];
    logic [pfds_pkg::NUM_RW-1:0] cfg_we;
    logic [pfds_pkg::REG_W-1:0] wr_byte;

    // Only the low byte lane carries data; the upper lanes are ignored.
    assign wr_byte = pwdata_i[pfds_pkg::REG_W-1:0];

    // One register per entry, each with its own mask and reset value so
    // absent bits stay zero whatever software writes into them.
    for (genvar k = 0; k < pfds_pkg::NUM_RW; k++) begin : g_cfg
        assign cfg_we[k] = wr_go
            && (reg_idx == pfds_pkg::IDX_W'(k)); // R14
        pfds_cfg_reg #(
            .MASK(pfds_pkg::RW_MASK[k]),
            .RST(pfds_pkg::RW_RST[k])
        ) u_reg (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .we_i(cfg_we[k]),
            .wdata_i(wr_byte),
            .q_o(cfg_q[k])
        );
    end

    // ------------------------------------------------------------------
    // Named views of the stored registers
    // ------------------------------------------------------------------

    logic [pfds_pkg::REG_W-1:0] lvl_reg2;
    logic [pfds_pkg::REG_W-1:0] lvl_reg3;
    logic [pfds_pkg::REG_W-1:0] route0;
    logic [pfds_pkg::REG_W-1:0] route1;

    assign lvl_reg2 = cfg_q[pfds_pkg::IDX_DRV_LVL_2];
    assign lvl_reg3 = cfg_q[pfds_pkg::IDX_DRV_LVL_3]; // R06

    // Drive code fields, one per pin group.
    logic [1:0] pf_high_drive_level;
    logic [1:0] pf_low_drive_level;
    logic [1:0] pe_high_drive_level;
    logic [1:0] pe_low_drive_level;
    logic [1:0] pg_drive_level;

    assign pf_high_drive_level =
        lvl_reg2[pfds_pkg::DRV_PF_HI_LSB +: pfds_pkg::DRV_FLD_W]; // R02
    assign pf_low_drive_level =
        lvl_reg2[pfds_pkg::DRV_PF_LO_LSB +: pfds_pkg::DRV_FLD_W]; // R03
    assign pe_high_drive_level =
        lvl_reg2[pfds_pkg::DRV_PE_HI_LSB +: pfds_pkg::DRV_FLD_W]; // R04
    assign pe_low_drive_level =
        lvl_reg2[pfds_pkg::DRV_PE_LO_LSB +: pfds_pkg::DRV_FLD_W]; // R05
    assign pg_drive_level =
        lvl_reg3[pfds_pkg::DRV_PG_LSB +: pfds_pkg::DRV_FLD_W]; // R07

    // ------------------------------------------------------------------
    // Output function selection, two bits per pin
    // ------------------------------------------------------------------

    // Each low register covers pins 3..0 (2..0 on port G) and each high register pins 7..4 (5..4 on port C),
    // so the concatenation lands every code on its own pin index.
    assign func_sel_o.pa = {cfg_q[pfds_pkg::IDX_PA_FUNC_HI],
        cfg_q[pfds_pkg::IDX_PA_FUNC_LO]}; // R08
    assign func_sel_o.pb = cfg_q[pfds_pkg::IDX_PB_FUNC_LO];
    assign func_sel_o.pc = {cfg_q[pfds_pkg::IDX_PC_FUNC_HI][3:0],
        cfg_q[pfds_pkg::IDX_PC_FUNC_LO]};
    assign func_sel_o.pd = {cfg_q[pfds_pkg::IDX_PD_FUNC_HI],
        cfg_q[pfds_pkg::IDX_PD_FUNC_LO]};
    assign func_sel_o.pe = {cfg_q[pfds_pkg::IDX_PE_FUNC_HI],
        cfg_q[pfds_pkg::IDX_PE_FUNC_LO]};
    assign func_sel_o.pf = {cfg_q[pfds_pkg::IDX_PF_FUNC_HI],
        cfg_q[pfds_pkg::IDX_PF_FUNC_LO]};
    assign func_sel_o.pg = cfg_q[pfds_pkg::IDX_PG_FUNC_LO][5:0];

    // ------------------------------------------------------------------
    // Input routing selection
    // ------------------------------------------------------------------

    assign route0 = cfg_q[pfds_pkg::IDX_IN_ROUTE_0];
    assign route1 = cfg_q[pfds_pkg::IDX_IN_ROUTE_1];

    // Each bit moves one peripheral input to its alternative pin.
    assign in_route_o.capture2_input_pin_route =
        route0[pfds_pkg::RT0_CAP2]; // R08
    assign in_route_o.capture1_input_pin_route =
        route0[pfds_pkg::RT0_CAP1];
    assign in_route_o.timer2_clock_pin_route =
        route0[pfds_pkg::RT0_TMR2_CLK];
    assign in_route_o.std_timer_clock_pin_route =
        route0[pfds_pkg::RT0_STD_CLK];
    assign in_route_o.serial_a_select_pin_route =
        route1[pfds_pkg::RT1_SER_A_SEL];
    assign in_route_o.serial_a_data_in_pin_route =
        route1[pfds_pkg::RT1_SER_A_DIN];
    assign in_route_o.serial_a_clock_pin_route =
        route1[pfds_pkg::RT1_SER_A_CLK];

    // ------------------------------------------------------------------
    // Pin direction
    // ------------------------------------------------------------------

    // A set bit makes the pin an input; the reset value of all ones keeps
    // every pin off the board until software chooses to drive it. The
    // input-function pins that share the GPIO code also rely on this bit.
    assign dir_in_o.pa = cfg_q[pfds_pkg::IDX_DIR_PA]; // R12
    assign dir_in_o.pb = cfg_q[pfds_pkg::IDX_DIR_PA + 1][3:0]; // R10
    assign dir_in_o.pc = cfg_q[pfds_pkg::IDX_DIR_PA + 2][5:0];
    assign dir_in_o.pd = cfg_q[pfds_pkg::IDX_DIR_PA + 3];
    assign dir_in_o.pe = cfg_q[pfds_pkg::IDX_DIR_PA + 4];
    assign dir_in_o.pf = cfg_q[pfds_pkg::IDX_DIR_PA + 5];
    assign dir_in_o.pg = cfg_q[pfds_pkg::IDX_DIR_PG][2:0];

    // ------------------------------------------------------------------
    // Effective source-current level per pin
    // ------------------------------------------------------------------

    logic [pfds_pkg::DRV_PINS-1:0] drv_dir_flat;
    logic [pfds_pkg::NUM_GRP-1:0][1:0] grp_code;
    pfds_pkg::pfds_pin_drv_t [pfds_pkg::DRV_PINS-1:0] drv_flat;
    pfds_pkg::pfds_drive_t drv_nxt;
    pfds_pkg::pfds_drive_t drv_r;

    // Pins 0..7 are port E, 8..15 port F, 16..18 port G; groups of four
    // pins share one code, and port G is the fifth group of three.
    assign drv_dir_flat = {dir_in_o.pg, dir_in_o.pf, dir_in_o.pe};
    assign grp_code = {pg_drive_level, pf_high_drive_level,
        pf_low_drive_level, pe_high_drive_level, pe_low_drive_level};

    // A pin set as input reports no drive and the lowest level, so the
    // pad never sees a stale strength when it turns back into an output.
    for (genvar p = 0; p < pfds_pkg::DRV_PINS; p++) begin : g_drv
        localparam int GRP = p / pfds_pkg::GRP_PINS;
        assign drv_flat[p].act = ~drv_dir_flat[p]; // R12
        assign drv_flat[p].lvl = drv_dir_flat[p]
            ? pfds_pkg::LVL_MIN
            : pfds_pkg::pfds_lvl_t'(grp_code[GRP]); // R01 R13
    end

    assign drv_nxt = pfds_pkg::pfds_drive_t'(drv_flat);

    // Registered so the pad controls change once, one edge after a write.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drv_r <= '0;
        end else begin
            drv_r <= drv_nxt;
        end
    end

    assign drive_o = drv_r;

    // ------------------------------------------------------------------
    // Read-only drive status
    // ------------------------------------------------------------------

    logic [7:0] act_pe;
    logic [7:0] act_pf;
    logic [7:0] act_pg;

    // These show which pins the block is really driving right now.
    for (genvar b = 0; b < 8; b++) begin : g_act
        assign act_pe[b] = drv_r.pe[b].act;
        assign act_pf[b] = drv_r.pf[b].act;
        if (b < 3) begin : g_g
            assign act_pg[b] = drv_r.pg[b].act;
        end else begin : g_z
            assign act_pg[b] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------

    logic [pfds_pkg::REG_W-1:0] rw_byte;
    logic [pfds_pkg::REG_W-1:0] ro_byte;
    logic [pfds_pkg::REG_W-1:0] rd_byte;
    logic rd_is_rw;

    // Stored registers hold zeros in absent bits, so a plain read already
    // returns zero there; unmapped addresses read as zero with an error.
    assign rd_is_rw = reg_idx < pfds_pkg::IDX_W'(pfds_pkg::NUM_RW);
    assign rw_byte = rd_is_rw
        ? cfg_q[reg_idx[4:0]] : '0; // R06 R14
    assign ro_byte =
        (reg_idx == pfds_pkg::IDX_W'(pfds_pkg::IDX_DRV_ACT_PE)) ? act_pe :
        (reg_idx == pfds_pkg::IDX_W'(pfds_pkg::IDX_DRV_ACT_PF)) ? act_pf :
        (reg_idx == pfds_pkg::IDX_W'(pfds_pkg::IDX_DRV_ACT_PG)) ? act_pg :
        '0;
    assign rd_byte = !addr_hit ? '0 : (rd_is_rw ? rw_byte : ro_byte);
    assign rd_word = {{(pfds_pkg::DATA_W - pfds_pkg::REG_W){1'b0}}, rd_byte};

endmodule

//--- dv/pfds_asserts.sv
// Concurrent checks on the ports of the pin function and drive select block.
`timescale 1ns/1ps
module pfds_asserts (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [pfds_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [pfds_pkg::DATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [pfds_pkg::DATA_W-1:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Pin configuration.
    input wire pfds_pkg::pfds_func_t func_sel_o,
    input wire pfds_pkg::pfds_dir_t dir_in_o,
    input wire pfds_pkg::pfds_drive_t drive_o,
    input wire pfds_pkg::pfds_route_t in_route_o
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // A write takes effect only at the edge where the access phase meets pready.
    wire logic wr_fire;
    wire logic setup;
    assign wr_fire = psel_i & penable_i & pwrite_i & pready_o;
    assign setup = psel_i & ~penable_i;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_ready_single_cycle: assert property (
        setup |=> pready_o ##1 !pready_o) else $error("pready not a single cycle after setup");
    a_bad_addr_error: assert property (
        pready_o && (paddr_i >= 12'h068 || paddr_i[1:0] != 2'h0) |-> pslverr_o && prdata_o == '0)
        else $error("bad address not refused");
    a_lvl3_upper_zero: assert property (
        pready_o && !pwrite_i && paddr_i == 12'h004 |-> prdata_o[31:2] == '0)
        else $error("absent level bits read nonzero");
    a_select_on_write: assert property (
        $changed(func_sel_o) || $changed(in_route_o) |-> $past(wr_fire))
        else $error("selection changed without a write");
    a_drive_on_write: assert property (
        $changed(drive_o) |-> $past(wr_fire, 2)) else $error("drive changed without a write");
    a_act_from_dir: assert property (
        drive_o.pe[0].act == !$past(dir_in_o.pe[0]) && drive_o.pg[2].act == !$past(dir_in_o.pg[2]))
        else $error("drive active does not follow direction");
    a_input_level_zero: assert property (
        !drive_o.pe[7].act |-> drive_o.pe[7].lvl == pfds_pkg::LVL_MIN)
        else $error("input pin carries a level");
    a_pf_high_group: assert property (
        drive_o.pf[7].act && drive_o.pf[4].act |-> drive_o.pf[7].lvl == drive_o.pf[4].lvl)
        else $error("port F upper group levels differ");
    a_pe_low_group: assert property (
        drive_o.pe[3].act && drive_o.pe[0].act |-> drive_o.pe[3].lvl == drive_o.pe[0].lvl)
        else $error("port E lower group levels differ");
    a_pg_group: assert property (
        drive_o.pg[2].act && drive_o.pg[0].act |-> drive_o.pg[2].lvl == drive_o.pg[0].lvl)
        else $error("port G levels differ");

    // Main scenarios seen.
    cover property (wr_fire);
    cover property (pready_o && pslverr_o);
    cover property (drive_o.pf[7].lvl == pfds_pkg::LVL_MAX);
endmodule

bind pfds_top pfds_asserts pfds_asserts_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .func_sel_o(func_sel_o), .dir_in_o(dir_in_o), .drive_o(drive_o), .in_route_o(in_route_o));

//--- dv/pin_function_and_drive_select_tb.sv
// Self-checking bench for the pin function and drive select block.
`timescale 1ns/1ps
module pin_function_and_drive_select_tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk_sys_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic psel_i = 1'h0;
    logic penable_i = 1'h0;
    logic pwrite_i = 1'h0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0] pstrb_i = 4'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    pfds_pkg::pfds_func_t func_sel_o;
    pfds_pkg::pfds_dir_t dir_in_o;
    pfds_pkg::pfds_drive_t drive_o;
    pfds_pkg::pfds_route_t in_route_o;
    pfds_pkg::pfds_drive_t exp_drv;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;
    logic act;

    pfds_top pfds_top_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .func_sel_o(func_sel_o), .dir_in_o(dir_in_o), .drive_o(drive_o),
        .in_route_o(in_route_o));

    // 40 MHz clock.
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // A hang is cut short well above the few hundred cycles the tests need.
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
            input logic [3:0] st);
        @(posedge clk_sys_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        pstrb_i <= st;
        @(posedge clk_sys_i);
        penable_i <= 1'h1;
        @(posedge clk_sys_i);
        while (pready_o !== 1'h1) begin
            @(posedge clk_sys_i);
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask

    task automatic wr(input int idx, input logic [7:0] d);
        apb(1'h1, 12'(idx * 4), d, 4'hF);
    endtask

    // Reads a register and compares data and error flag together.
    task automatic rdc(input int idx, input logic [7:0] e);
        apb(1'h0, 12'(idx * 4), 8'h00, 4'hF);
        check({er, rd}, {25'h0, e});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        // Reset values, read-only places included.
        for (int i = 0; i < 26; i++) begin
            rdc(i, i < 23 ? pfds_pkg::RW_RST[i] : 8'h00);
        end
        // Absent bits ignore ones and read zero.
        for (int i = 0; i < pfds_pkg::NUM_RW; i++) begin
            wr(i, 8'hFF);
            rdc(i, pfds_pkg::RW_MASK[i]);
            wr(i, 8'h00);
            rdc(i, 8'h00);
        end
        // Unmapped, unaligned and lane-0-strobe-less accesses change nothing.
        apb(1'h0, 12'h068, 8'h00, 4'hF);
        check({er, rd}, 33'h1_0000_0000);
        apb(1'h1, 12'h009, 8'hFF, 4'hF);
        check(er, 1'h1);
        apb(1'h1, 12'h008, 8'hFF, 4'hE);
        rdc(pfds_pkg::IDX_PA_FUNC_LO, 8'h00);
        // Function first, then direction, as software must do it.
        wr(pfds_pkg::IDX_PA_FUNC_LO, 8'hE4);
        wr(pfds_pkg::IDX_PA_FUNC_HI, 8'h1B);
        wr(pfds_pkg::IDX_PG_FUNC_LO, 8'hED);
        wr(pfds_pkg::IDX_PC_FUNC_HI, 8'hA5);
        wr(pfds_pkg::IDX_PC_FUNC_LO, 8'h3C);
        wr(pfds_pkg::IDX_IN_ROUTE_0, 8'hFF);
        wr(pfds_pkg::IDX_DIR_PA, 8'h5A);
        @(posedge clk_sys_i);
        check(func_sel_o.pa, 16'h1BE4);
        check(func_sel_o.pg, 6'h2D);
        check(func_sel_o.pc, 12'h53C);
        check(in_route_o, 7'h78);
        check(dir_in_o.pa, 8'h5A);
        wr(pfds_pkg::IDX_IN_ROUTE_0, 8'h00);
        wr(pfds_pkg::IDX_IN_ROUTE_1, 8'hFF);
        @(posedge clk_sys_i);
        check(in_route_o, 7'h07);
        // Every code on the port F and G groups, codes 0 and 2 on port E; port E halves swap between input and output.
        for (int k = 0; k < 4; k++) begin
            wr(pfds_pkg::IDX_DIR_PA + 4, k[0] ? 8'h0F : 8'hF0);
            wr(pfds_pkg::IDX_DRV_LVL_2, {2'(k + 3), 2'(k + 2), 2'(k + 1), 2'(k)});
            wr(pfds_pkg::IDX_DRV_LVL_3, 8'(k));
            rdc(pfds_pkg::IDX_DRV_ACT_PE, k[0] ? 8'hF0 : 8'h0F);
            for (int p = 0; p < 8; p++) begin
                act = k[0] ? (p >= 4) : (p < 4);
                exp_drv.pe[p].act = act;
                exp_drv.pe[p].lvl = pfds_pkg::pfds_lvl_t'(act ? 2'(p < 4 ? k : k + 1) : 2'h0);
                exp_drv.pf[p].act = 1'h1;
                exp_drv.pf[p].lvl = pfds_pkg::pfds_lvl_t'(2'(p < 4 ? k + 2 : k + 3));
                if (p < 3) begin
                    exp_drv.pg[p].act = 1'h1;
                    exp_drv.pg[p].lvl = pfds_pkg::pfds_lvl_t'(2'(k));
                end
            end
            check(drive_o, exp_drv);
        end
        // Read-only drive-active words ignore writes.
        wr(pfds_pkg::IDX_DRV_ACT_PF, 8'h00);
        rdc(pfds_pkg::IDX_DRV_ACT_PF, 8'hFF);
        rdc(pfds_pkg::IDX_DRV_ACT_PG, 8'h07);
        // A second reset in mid-run restores every field.
        @(posedge clk_sys_i);
        rst_n_i <= 1'h0;
        repeat (2) @(posedge clk_sys_i);
        check(dir_in_o, {45{1'h1}});
        check(func_sel_o[89:45], 45'h0);
        check(func_sel_o[44:0], 45'h0);
        check({in_route_o, drive_o}, 64'h0);
        rst_n_i <= 1'h1;
        rdc(pfds_pkg::IDX_DRV_LVL_2, 8'h00);
        report_and_stop();
    end
endmodule
